// ---- adc_seq_pkg.sv ----
// Shared constants, register layouts and types of the converter sequencer
package adc_seq_pkg;

  // Timing
  localparam int CLK_PERIOD_NS  = 4;
  localparam int TCY_NS         = 16;
  localparam int TCY_CYCLES     = (TCY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONV_TADS      = 11;
  localparam int RECOVER_TADS   = 2;
  localparam int RESULT_BITS    = 10;
  localparam int NUM_INPUTS     = 13;
  localparam int DIV_WIDTH      = 7;

  // Register byte offsets
  localparam logic [4:0] OFS_CTRL0   = 5'h00;
  localparam logic [4:0] OFS_CTRL1   = 5'h04;
  localparam logic [4:0] OFS_CTRL2   = 5'h08;
  localparam logic [4:0] OFS_RES_LO  = 5'h0C;
  localparam logic [4:0] OFS_RES_HI  = 5'h10;
  localparam logic [4:0] OFS_STATUS  = 5'h14;

  // Field positions not covered by the struct layouts
  localparam int STATUS_FLAG_BIT = 0;
  localparam int CTRL0_GO_BIT    = 1;
  localparam int CTRL0_EN_BIT    = 0;

  // Reset values and decode limits
  localparam logic [3:0] PCFG_RST_ANALOG  = 4'h0;
  localparam logic [3:0] PCFG_RST_DIGITAL = 4'h7;
  localparam logic [3:0] CHAN_MAX         = 4'hC;
  localparam logic [3:0] PCFG_ALL_ANALOG  = 4'h2;

  // Clock select codes that pick the internal RC clock have both low bits set
  localparam logic [1:0] CS_RC_LOW = 2'h3;

  typedef struct packed {
    logic [3:0] channel_select;
    logic       go;
    logic       module_enable;
  } ctrl0_t;

  typedef struct packed {
    logic       neg_reference_select;
    logic       pos_reference_select;
    logic [3:0] port_config;
  } ctrl1_t;

  typedef struct packed {
    logic       result_format;
    logic [2:0] acquisition_select;
    logic [2:0] conversion_clock_select;
  } ctrl2_t;

  // Drive toward the analog front end
  typedef struct packed {
    logic [3:0]             channel_select;
    logic                   channel_valid;
    logic [NUM_INPUTS-1:0]  analog_mask;
    logic                   neg_reference_select;
    logic                   pos_reference_select;
    logic                   sample_enable;
    logic [RESULT_BITS-1:0] trial_code;
  } afe_drive_t;

  typedef enum logic [2:0] {
    SEQ_IDLE    = 3'b000,
    SEQ_DELAY   = 3'b001,
    SEQ_ACQUIRE = 3'b010,
    SEQ_CONVERT = 3'b011,
    SEQ_RECOVER = 3'b100
  } seq_state_t;

endpackage : adc_seq_pkg

// ---- adc_tad_clock.sv ----
// Conversion-bit period tick generator
`timescale 1ns/100ps
module adc_tad_clock #(
  parameter int DIV_W = adc_seq_pkg::DIV_WIDTH
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // Control
  input  wire logic       run,
  input  wire logic [2:0] clock_select,
  input  wire logic       rc_edge,
  // Tick
  output logic            tad_tick
);
  import adc_seq_pkg::*;

  if (DIV_W < 7) begin : g_chk
    $error("adc_tad_clock: DIV_W must hold a divide of 64");
  end

  function automatic logic [DIV_W-1:0] divide_of(input logic [2:0] code);
    case (code)
      3'b000:  divide_of = DIV_W'(2);
      3'b001:  divide_of = DIV_W'(8);
      3'b010:  divide_of = DIV_W'(32);
      3'b100:  divide_of = DIV_W'(4);
      3'b101:  divide_of = DIV_W'(16);
      3'b110:  divide_of = DIV_W'(64);
      default: divide_of = DIV_W'(2);
    endcase
  endfunction : divide_of

  logic [DIV_W-1:0] count_ff;
  logic             use_rc;

  assign use_rc   = (clock_select[1:0] == CS_RC_LOW);
  assign tad_tick = run & (use_rc ? rc_edge
                                  : (count_ff == divide_of(clock_select) - DIV_W'(1)));

  // Counter restarts whenever the sequencer stops, so each run begins a whole period
  always_ff @(posedge clk) begin
    if (sys_rst || !run || tad_tick) begin
      count_ff <= '0;
    end else begin
      count_ff <= count_ff + DIV_W'(1);
    end
  end

endmodule : adc_tad_clock

// ---- adc_sar_engine.sv ----
// Successive-approximation bit engine, one setup tick then one decision per tick
`timescale 1ns/100ps
module adc_sar_engine #(
  parameter int BITS = adc_seq_pkg::RESULT_BITS
) (
  // Clock and reset
  input  wire logic            clk,
  input  wire logic            sys_rst,
  // Control
  input  wire logic            start,
  input  wire logic            abort,
  input  wire logic            tad_tick,
  input  wire logic            cmp_high,
  // Results
  output logic [BITS-1:0]      trial_code,
  output logic [BITS-1:0]      result,
  output logic                 done
);
  import adc_seq_pkg::*;

  if (BITS + 1 != CONV_TADS) begin : g_chk
    $error("adc_sar_engine: one setup period plus one per bit expected");
  end

  logic [3:0]      cnt_ff;
  logic            busy_ff;
  logic [BITS-1:0] trial_ff;
  logic [BITS-1:0] nxt_trial;
  logic [BITS-1:0] result_ff;
  logic            done_ff;
  int              idx;

  assign trial_code = trial_ff;
  assign result     = result_ff;
  assign done       = done_ff;

  always_comb begin
    idx       = BITS - int'(cnt_ff);
    nxt_trial = trial_ff;
    if (cnt_ff == 4'h0) begin
      nxt_trial = {1'b1, {(BITS-1){1'b0}}};
    end else begin
      nxt_trial[idx] = cmp_high;
      if (idx != 0) begin
        nxt_trial[idx-1] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || abort) begin
      busy_ff  <= 1'b0;
      cnt_ff   <= 4'h0;
      trial_ff <= '0;
    end else if (start) begin
      busy_ff  <= 1'b1;
      cnt_ff   <= 4'h0;
      trial_ff <= '0;
    end else if (busy_ff && tad_tick) begin
      trial_ff <= nxt_trial;
      if (cnt_ff == 4'(BITS)) begin
        busy_ff <= 1'b0;
        cnt_ff  <= 4'h0;
      end else begin
        cnt_ff <= cnt_ff + 4'h1;
      end
    end
  end

  // Last decision lands in the result; no reset on the result itself
  always_ff @(posedge clk) begin
    if (busy_ff && tad_tick && cnt_ff == 4'(BITS)) begin
      result_ff <= nxt_trial;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || abort) begin
      done_ff <= 1'b0;
    end else begin
      done_ff <= busy_ff & tad_tick & (cnt_ff == 4'(BITS));
    end
  end

endmodule : adc_sar_engine

// ---- adc_sequencer_control.sv ----
// Converter control registers, acquisition sequencer and result formatting
`timescale 1ns/100ps
module adc_sequencer_control #(
  parameter int INPUTS = adc_seq_pkg::NUM_INPUTS
) (
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    sys_rst,
  // Avalon-MM register slave
  input  wire logic [4:0]              avs_address,
  input  wire logic                    avs_read,
  input  wire logic                    avs_write,
  input  wire logic [31:0]             avs_writedata,
  input  wire logic [3:0]              avs_byteenable,
  output logic [31:0]                  avs_readdata,
  output logic                         avs_waitrequest,
  // Configuration fuse and RC oscillator pins
  input  wire logic                    analog_default_fuse,
  input  wire logic                    internal_rc_clock,
  // Analog front end
  input  wire logic                    cmp_high,
  output adc_seq_pkg::afe_drive_t      afe_drive,
  // Status toward the interrupt controller
  output logic                         converter_irq_flag
);
  import adc_seq_pkg::*;

  if (INPUTS != NUM_INPUTS) begin : g_chk
    $error("adc_sequencer_control: port decode serves exactly 13 inputs");
  end

  // Register state
  ctrl0_t                 ctrl0_ff;
  ctrl1_t                 ctrl1_ff;
  ctrl2_t                 ctrl2_ff;
  logic [7:0]             result_low_ff;
  logic [7:0]             result_high_ff;
  logic                   irq_flag_ff;

  // Bus handshake
  logic                   ack_ff;
  logic [31:0]            readdata_ff;
  logic [31:0]            nxt_readdata;
  logic                   wr_take;
  logic                   wr_lane0;

  // Pin synchronisers
  logic                   fuse_meta_ff;
  logic                   fuse_sync_ff;
  logic                   rc_meta_ff;
  logic                   rc_sync_ff;
  logic                   rc_prev_ff;
  logic                   rc_edge;

  // Sequencer
  seq_state_t             state_ff;
  seq_state_t             nxt_state;
  logic [4:0]             tad_cnt_ff;
  logic [4:0]             nxt_tad_cnt;
  logic [1:0]             delay_cnt_ff;
  logic                   tad_run;
  logic                   tad_tick;
  logic                   sar_start;
  logic                   sar_abort;
  logic                   sar_done;
  logic [RESULT_BITS-1:0] sar_result;
  logic [RESULT_BITS-1:0] sar_trial;
  logic                   go_set;
  logic                   use_rc;
  logic [4:0]             acq_tads;

  function automatic logic [4:0] acq_length(input logic [2:0] code);
    case (code)
      3'b000:  acq_length = 5'h00;
      3'b001:  acq_length = 5'h02;
      3'b010:  acq_length = 5'h04;
      3'b011:  acq_length = 5'h06;
      3'b100:  acq_length = 5'h08;
      3'b101:  acq_length = 5'h0C;
      3'b110:  acq_length = 5'h10;
      default: acq_length = 5'h14;
    endcase
  endfunction : acq_length

  function automatic logic [NUM_INPUTS-1:0] analog_of(input logic [3:0] code);
    logic [NUM_INPUTS-1:0] m;
    m = '1;
    if (code > PCFG_ALL_ANALOG) begin
      for (int i = 0; i < NUM_INPUTS; i++) begin
        m[i] = (i < 15 - int'(code));
      end
    end
    analog_of = m;
  endfunction : analog_of

  assign acq_tads = acq_length(ctrl2_ff.acquisition_select);
  assign use_rc   = (ctrl2_ff.conversion_clock_select[1:0] == CS_RC_LOW);

  // ---------------------------------------------------------------- bus
  // One wait cycle per access; the request completes at the second edge
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_ff;
  assign avs_readdata    = readdata_ff;
  assign wr_take         = avs_write & ack_ff;
  assign wr_lane0        = wr_take & avs_byteenable[0];

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= (avs_read | avs_write) & ~ack_ff;
    end
  end

  always_comb begin
    nxt_readdata = 32'h0000_0000;
    case (avs_address)
      OFS_CTRL0:  nxt_readdata = {26'h0, ctrl0_ff};
      OFS_CTRL1:  nxt_readdata = {26'h0, ctrl1_ff};
      OFS_CTRL2:  nxt_readdata = {24'h0, ctrl2_ff.result_format, 1'b0,
                                  ctrl2_ff.acquisition_select,
                                  ctrl2_ff.conversion_clock_select};
      OFS_RES_LO: nxt_readdata = {24'h0, result_low_ff};
      OFS_RES_HI: nxt_readdata = {24'h0, result_high_ff};
      OFS_STATUS: nxt_readdata = {31'h0, irq_flag_ff};
      default:    nxt_readdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      readdata_ff <= 32'h0000_0000;
    end else if (avs_read && !ack_ff) begin
      readdata_ff <= nxt_readdata;
    end
  end

  // ---------------------------------------------------------------- pins
  always_ff @(posedge clk) begin
    fuse_meta_ff <= analog_default_fuse;
    fuse_sync_ff <= fuse_meta_ff;
    rc_meta_ff   <= internal_rc_clock;
    rc_sync_ff   <= rc_meta_ff;
    rc_prev_ff   <= rc_sync_ff;
  end

  assign rc_edge = rc_sync_ff & ~rc_prev_ff;

  // ---------------------------------------------------------------- control 0
  assign go_set = wr_lane0 && (avs_address == OFS_CTRL0)
                  && avs_writedata[CTRL0_GO_BIT] && avs_writedata[CTRL0_EN_BIT];

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl0_ff <= '0;
    end else begin
      if (wr_lane0 && avs_address == OFS_CTRL0) begin
        ctrl0_ff.channel_select <= avs_writedata[5:2];
        ctrl0_ff.module_enable  <= avs_writedata[CTRL0_EN_BIT];
      end
      // Start request wins over a completion in the same cycle
      if (go_set) begin
        ctrl0_ff.go <= 1'b1;
      end else if (sar_done) begin
        ctrl0_ff.go <= 1'b0;
      end else if (!ctrl0_ff.module_enable) begin
        ctrl0_ff.go <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------- control 1
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl1_ff.neg_reference_select <= 1'b0;
      ctrl1_ff.pos_reference_select <= 1'b0;
      ctrl1_ff.port_config <= fuse_sync_ff ? PCFG_RST_ANALOG
                                           : PCFG_RST_DIGITAL;
    end else if (wr_lane0 && avs_address == OFS_CTRL1) begin
      ctrl1_ff <= avs_writedata[5:0];
    end
  end

  // ---------------------------------------------------------------- control 2
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl2_ff <= '0;
    end else if (wr_lane0 && avs_address == OFS_CTRL2) begin
      ctrl2_ff.result_format           <= avs_writedata[7];
      ctrl2_ff.acquisition_select      <= avs_writedata[5:3];
      ctrl2_ff.conversion_clock_select <= avs_writedata[2:0];
    end
  end

  // ---------------------------------------------------------------- sequencer
  assign sar_abort = ~ctrl0_ff.module_enable;
  assign sar_start = (state_ff != SEQ_CONVERT) && (nxt_state == SEQ_CONVERT);
  assign tad_run   = (state_ff == SEQ_ACQUIRE) || (state_ff == SEQ_CONVERT)
                     || (state_ff == SEQ_RECOVER);

  always_comb begin
    nxt_state   = state_ff;
    nxt_tad_cnt = tad_cnt_ff;
    case (state_ff)
      SEQ_IDLE: begin
        nxt_tad_cnt = 5'h00;
        if (ctrl0_ff.go) begin
          if (use_rc) begin
            nxt_state = SEQ_DELAY;
          end else if (acq_tads != 5'h00) begin
            nxt_state = SEQ_ACQUIRE;
          end else begin
            nxt_state = SEQ_CONVERT;
          end
        end
      end
      SEQ_DELAY: begin
        if (delay_cnt_ff == 2'(TCY_CYCLES - 1)) begin
          nxt_state = (acq_tads != 5'h00) ? SEQ_ACQUIRE : SEQ_CONVERT;
        end
      end
      SEQ_ACQUIRE: begin
        if (tad_tick) begin
          nxt_tad_cnt = tad_cnt_ff + 5'h01;
          if (nxt_tad_cnt == acq_tads) begin
            nxt_state   = SEQ_CONVERT;
            nxt_tad_cnt = 5'h00;
          end
        end
      end
      SEQ_CONVERT: begin
        nxt_tad_cnt = 5'h00;
        if (sar_done) begin
          nxt_state = SEQ_RECOVER;
        end
      end
      SEQ_RECOVER: begin
        if (tad_tick) begin
          nxt_tad_cnt = tad_cnt_ff + 5'h01;
          if (nxt_tad_cnt == 5'(RECOVER_TADS)) begin
            nxt_state   = SEQ_IDLE;
            nxt_tad_cnt = 5'h00;
          end
        end
      end
      default: begin
        nxt_state   = SEQ_IDLE;
        nxt_tad_cnt = 5'h00;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst || !ctrl0_ff.module_enable) begin
      state_ff   <= SEQ_IDLE;
      tad_cnt_ff <= 5'h00;
    end else begin
      state_ff   <= nxt_state;
      tad_cnt_ff <= nxt_tad_cnt;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || state_ff != SEQ_DELAY) begin
      delay_cnt_ff <= 2'h0;
    end else begin
      delay_cnt_ff <= delay_cnt_ff + 2'h1;
    end
  end

  adc_tad_clock #(
    .DIV_W        (DIV_WIDTH)
  ) u_tad_clock (
    .clk          (clk),
    .sys_rst      (sys_rst),
    .run          (tad_run),
    .clock_select (ctrl2_ff.conversion_clock_select),
    .rc_edge      (rc_edge),
    .tad_tick     (tad_tick)
  );

  adc_sar_engine #(
    .BITS       (RESULT_BITS)
  ) u_sar (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .start      (sar_start),
    .abort      (sar_abort),
    .tad_tick   (tad_tick),
    .cmp_high   (cmp_high),
    .trial_code (sar_trial),
    .result     (sar_result),
    .done       (sar_done)
  );

  // ---------------------------------------------------------------- results
  // Pair keeps its contents across reset
  always_ff @(posedge clk) begin
    if (sar_done) begin
      if (ctrl2_ff.result_format) begin
        result_high_ff <= {6'h00, sar_result[9:8]};
        result_low_ff  <= sar_result[7:0];
      end else begin
        result_high_ff <= sar_result[9:2];
        result_low_ff  <= {sar_result[1:0], 6'h00};
      end
    end
  end

  // Completion sets the flag even while software clears it
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_flag_ff <= 1'b0;
    end else if (sar_done) begin
      irq_flag_ff <= 1'b1;
    end else if (wr_lane0 && avs_address == OFS_STATUS
                 && avs_writedata[STATUS_FLAG_BIT]) begin
      irq_flag_ff <= 1'b0;
    end
  end

  assign converter_irq_flag = irq_flag_ff;

  // ---------------------------------------------------------------- front end
  always_comb begin
    afe_drive.channel_select       = ctrl0_ff.channel_select;
    afe_drive.channel_valid        = (ctrl0_ff.channel_select <= CHAN_MAX);
    afe_drive.analog_mask          = analog_of(ctrl1_ff.port_config);
    afe_drive.neg_reference_select = ctrl1_ff.neg_reference_select;
    afe_drive.pos_reference_select = ctrl1_ff.pos_reference_select;
    afe_drive.sample_enable        = ctrl0_ff.module_enable
                                     && (state_ff != SEQ_CONVERT);
    afe_drive.trial_code           = sar_trial;
  end

endmodule : adc_sequencer_control

// ---- adc_afe_model.sv ----
// Analog front end model: comparator, floating level on absent inputs
`timescale 1ns/100ps
module adc_afe_model (
  // Clock
  input  wire logic                    clk,
  // Drive and stimulus
  input  wire adc_seq_pkg::afe_drive_t afe_drive,
  input  wire logic [9:0]              level,
  // Comparator
  output logic                         cmp_high
);
  import adc_seq_pkg::*;
  logic float_ff = 1'b0;
  always @(posedge clk) begin
    float_ff <= ~float_ff;
  end
  // Absent input wanders every cycle
  assign cmp_high = afe_drive.channel_valid ? (level >= afe_drive.trial_code)
                                            : float_ff;
endmodule : adc_afe_model

// ---- adc_seq_props.sv ----
// Port checker for the converter sequencer
`timescale 1ns/100ps
module adc_seq_props #(
  parameter int INPUTS = 13
) (
  // Clock and reset
  input wire logic                    clk,
  input wire logic                    sys_rst,
  // Register bus
  input wire logic [4:0]              avs_address,
  input wire logic                    avs_read,
  input wire logic                    avs_write,
  input wire logic [31:0]             avs_writedata,
  input wire logic [3:0]              avs_byteenable,
  input wire logic [31:0]             avs_readdata,
  input wire logic                    avs_waitrequest,
  // Pins
  input wire logic                    analog_default_fuse,
  input wire logic                    internal_rc_clock,
  input wire logic                    cmp_high,
  input wire adc_seq_pkg::afe_drive_t afe_drive,
  input wire logic                    converter_irq_flag
);
  import adc_seq_pkg::*;
  logic [7:0] low_cnt_ff;
  logic       wr_done;
  assign wr_done = avs_write && !avs_waitrequest && avs_byteenable[0];
  // Length of the current sampling gap
  always_ff @(posedge clk) begin
    if (sys_rst || afe_drive.sample_enable)
      low_cnt_ff <= 8'h00;
    else if (low_cnt_ff != 8'hFF)
      low_cnt_ff <= low_cnt_ff + 8'h01;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  chan_write_a: assert property (wr_done && avs_address == OFS_CTRL0 |=>
    afe_drive.channel_select == $past(avs_writedata[5:2])) else $error("channel not taken");
  chan_valid_a: assert property (wr_done && avs_address == OFS_CTRL0 |=>
    afe_drive.channel_valid == ($past(avs_writedata[5:2]) <= 4'hC)) else $error("bad valid");
  ref_write_a: assert property (wr_done && avs_address == OFS_CTRL1 |=>
    {afe_drive.neg_reference_select, afe_drive.pos_reference_select} ==
    $past(avs_writedata[5:4])) else $error("reference not taken");
  mask_thermo_a: assert property (
    (afe_drive.analog_mask & (afe_drive.analog_mask + 13'h1)) == 13'h0) else $error("mask gap");
  reset_off_a: assert property (disable iff (1'b0) sys_rst |=>
    !converter_irq_flag && !afe_drive.sample_enable) else $error("reset left it on");
  recover_hold_a: assert property ($rose(converter_irq_flag) |->
    afe_drive.sample_enable [*4]) else $error("recovery too short");
  conv_len_a: assert property ($rose(converter_irq_flag) |->
    low_cnt_ff >= 8'd22) else $error("conversion too short");
  unimpl_zero_a: assert property (avs_read && !avs_waitrequest |->
    avs_readdata[31:8] == 24'h0 && !(avs_address == OFS_CTRL2 && avs_readdata[6]) &&
    !(avs_address < OFS_CTRL2 && |avs_readdata[7:6])) else $error("unused bits set");
endmodule : adc_seq_props

bind adc_sequencer_control adc_seq_props #(.INPUTS(INPUTS)) u_props (
  .clk(clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .analog_default_fuse(analog_default_fuse), .internal_rc_clock(internal_rc_clock),
  .cmp_high(cmp_high), .afe_drive(afe_drive), .converter_irq_flag(converter_irq_flag));

// ---- adc_sequencer_control_tb.sv ----
// Self-checking bench for the converter sequencer
`timescale 1ns/100ps
module adc_sequencer_control_tb;
  import adc_seq_pkg::*;
  typedef struct packed {
    logic [4:0] a;
    logic [7:0] d;
    logic       be;
    logic [7:0] e;
  } row_t;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [4:0]  avs_address = 5'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        fuse = 1'b1;
  logic        rc_pin = 1'b0;
  logic        cmp_high;
  logic [9:0]  level = 10'h000;
  afe_drive_t  afe_drive;
  logic        irq_flag;
  int          miscompares = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  int          t0;
  logic [7:0]  rd;
  row_t        rows [7] = '{'{OFS_CTRL1, 8'hFF, 1'b1, 8'h3F}, '{OFS_CTRL1, 8'h30, 1'b1, 8'h30},
    '{OFS_CTRL2, 8'hFF, 1'b1, 8'hBF}, '{OFS_CTRL2, 8'h07, 1'b0, 8'hBF},
    '{OFS_CTRL0, 8'hFE, 1'b1, 8'h3C}, '{5'h18, 8'hFF, 1'b1, 8'h00},
    '{OFS_STATUS, 8'h01, 1'b1, 8'h00}};
  always #2 clk = ~clk;
  // RC oscillator, one rising edge every ten clocks
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc % 5 == 4)
      rc_pin <= ~rc_pin;
  end
  adc_sequencer_control DUT (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .analog_default_fuse(fuse),
    .internal_rc_clock(rc_pin), .cmp_high(cmp_high), .afe_drive(afe_drive),
    .converter_irq_flag(irq_flag));
  adc_afe_model afe (.clk(clk), .afe_drive(afe_drive), .level(level), .cmp_high(cmp_high));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= wr;
    avs_read <= ~wr;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus
  task automatic reset_check(input logic [7:0] pcfg);
    for (int i = 0; i < 3; i++) begin
      bus(1'b0, 5'(4 * i), 8'h00);
      chk(rd, i == 1 ? pcfg : 8'h00);
    end
    chk({31'h0, irq_flag}, 32'h0);
  endtask : reset_check
  task automatic convert(input logic [7:0] c2, input logic [3:0] ch);
    int d;
    int a;
    d = c2[1:0] == 2'b11 ? 10 : (c2[2] ? 4 : 2) << (2 * c2[1:0]);
    a = c2[5] ? 8 + 4 * c2[4:3] : 2 * c2[4:3];
    // Let recovery run out, two periods of the slowest divide
    repeat (140) @(posedge clk);
    bus(1'b1, OFS_CTRL2, c2);
    bus(1'b1, OFS_CTRL0, {2'b00, ch, 2'b11});
    t0 = cyc;
    bus(1'b0, OFS_CTRL0, 8'h00);
    chk(rd, {2'b00, ch, 2'b11});
    while (irq_flag !== 1'b1) @(posedge clk);
    t0 = cyc - t0;
    chk(32'(t0 inside {[(a + 10) * d : (a + 12) * d + 8]}), 1);
    bus(1'b0, OFS_CTRL0, 8'h00);
    chk(rd, {2'b00, ch, 2'b01});
    bus(1'b0, OFS_RES_HI, 8'h00);
    if (ch <= 4'hC) chk(rd, c2[7] ? {6'h0, level[9:8]} : level[9:2]);
    bus(1'b0, OFS_RES_LO, 8'h00);
    if (ch <= 4'hC) chk(rd, c2[7] ? level[7:0] : {level[1:0], 6'h0});
    bus(1'b1, OFS_STATUS, 8'h01);
    bus(1'b0, OFS_STATUS, 8'h00);
    chk(rd, 8'h00);
  endtask : convert
  task automatic wrap_up;
    if (miscompares == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (40000) @(posedge clk);
    miscompares++;
    wrap_up();
  end
  initial begin
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    reset_check(8'h00);
    foreach (rows[k]) begin
      avs_byteenable <= {3'h7, rows[k].be};
      bus(1'b1, rows[k].a, rows[k].d);
      bus(1'b0, rows[k].a, 8'h00);
      chk(rd, rows[k].e);
    end
    for (int i = 0; i < 16; i++) begin
      bus(1'b1, OFS_CTRL1, 8'(i));
      bus(1'b1, OFS_CTRL0, {2'b00, 4'(i), 2'b00});
      @(posedge clk);
      chk(afe_drive.analog_mask, i < 3 ? 13'h1FFF : 13'h1FFF >> (i - 2));
      chk(afe_drive.channel_valid, i <= 12);
    end
    for (int i = 0; i < 8; i++) begin
      level <= 10'h3FF - 10'(i * 137);
      convert({i[0], 1'b0, i[2:0], i[2:0]}, 4'(i + 5));
    end
    level <= 10'h155;
    convert(8'h80, 4'hD);
    bus(1'b1, OFS_CTRL2, 8'h38);
    bus(1'b1, OFS_CTRL0, 8'h03);
    // Abort in the middle of the conversion phase
    repeat (45) @(posedge clk);
    bus(1'b1, OFS_CTRL0, 8'h00);
    bus(1'b0, OFS_CTRL0, 8'h00);
    chk(rd, 8'h00);
    chk({31'h0, afe_drive.sample_enable}, 32'h0);
    repeat (1500) @(posedge clk);
    chk({31'h0, irq_flag}, 32'h0);
    bus(1'b1, OFS_CTRL0, 8'h03);
    repeat (80) @(posedge clk);
    chk({31'h0, irq_flag}, 32'h1);
    bus(1'b1, OFS_CTRL0, 8'h03);
    fuse <= 1'b0;
    sys_rst <= 1'b1;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    reset_check(8'h07);
    bus(1'b0, OFS_RES_HI, 8'h00);
    chk(rd, level[9:2]);
    wrap_up();
  end
endmodule : adc_sequencer_control_tb
